// ---- verilog/pxp_pkg.sv ----
// Constants and types shared by the port expander serial front end
package pxp_pkg;

  // Fixed top three bits of the two slave addresses
  localparam logic [2:0] PXP_PFX_A = 3'h6;
  localparam logic [2:0] PXP_PFX_B = 3'h5;

  // Serial byte: bit counter value once all data bits are in
  localparam logic [3:0] PXP_BIT_FULL = 4'h8;
  localparam logic [3:0] PXP_BIT_LAST = 4'h7;

  // Output latch reset values of both groups
  localparam logic [7:0] PXP_RST_LAT_A = 8'hff;
  localparam logic [7:0] PXP_RST_LAT_B = 8'hff;

  // Group A byte: open-drain ports sit in bits 5..2
  localparam int PXP_IO_LSB = 2;
  localparam int PXP_IO_MSB = 5;

  // Address bits given by the low select pin
  localparam logic [1:0] PXP_LO_GND = 2'h0;
  localparam logic [1:0] PXP_LO_VDD = 2'h1;
  localparam logic [1:0] PXP_LO_SCL = 2'h2;
  localparam logic [1:0] PXP_LO_SDA = 2'h3;
  // Address bits given by the high select pin
  localparam logic [1:0] PXP_HI_SCL = 2'h0;
  localparam logic [1:0] PXP_HI_SDA = 2'h1;
  localparam logic [1:0] PXP_HI_GND = 2'h2;
  localparam logic [1:0] PXP_HI_VDD = 2'h3;

  typedef enum logic [1:0] {
    PXP_LVL_GND,
    PXP_LVL_VDD,
    PXP_LVL_SCL,
    PXP_LVL_SDA
  } pxp_lvl_e;

  typedef enum logic [2:0] {
    PXP_ST_IDLE,
    PXP_ST_ADDR,
    PXP_ST_ADDR_ACK,
    PXP_ST_WR_DATA,
    PXP_ST_WR_ACK,
    PXP_ST_RD_DATA,
    PXP_ST_RD_ACK,
    PXP_ST_IGNORE
  } pxp_st_e;

endpackage

// ---- verilog/pxp_sync.sv ----
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module pxp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  import pxp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } pxp_sync_s;

  pxp_sync_s q;
  pxp_sync_s d;

  // The first stage feeds only the second one
  always_comb begin
    d.meta = async_i;
    d.safe = q.meta;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      // All pads but the select straps idle high (pull-ups, released ports, latches reset
      // high), so starting high raises no false edge or change
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.safe;

endmodule
`default_nettype wire

// ---- verilog/pxp_lvl_dec.sv ----
// Four-level decoder for one address select pin
`timescale 1ns/10ps
`default_nettype none

module pxp_lvl_dec (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  input  wire logic             pin_i,
  output pxp_pkg::pxp_lvl_e     level_o
);
  import pxp_pkg::*;

  typedef struct packed {
    logic     mis_sda;
    logic     mis_scl;
    pxp_lvl_e level;
  } pxp_dec_s;

  pxp_dec_s q;
  pxp_dec_s d;

  // Only moments where SDA and SCL differ tell the strap apart
  always_comb begin
    d = q;
    if (scl_i != sda_i) begin
      if (pin_i != sda_i) begin
        d.mis_sda = 1'b1;
      end
      if (pin_i != scl_i) begin
        d.mis_scl = 1'b1;
      end
    end
    if (!d.mis_sda) begin
      d.level = PXP_LVL_SDA;
    end else if (!d.mis_scl) begin
      d.level = PXP_LVL_SCL;
    end else if (pin_i) begin
      d.level = PXP_LVL_VDD;
    end else begin
      d.level = PXP_LVL_GND;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{mis_sda: 1'b0, mis_scl: 1'b0, level: PXP_LVL_SDA};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule
`default_nettype wire

// ---- verilog/pxp_expander.sv ----
// Serial slave front end of the 16-port dual-address expander
`timescale 1ns/10ps
`default_nettype none

module pxp_expander #(
  parameter logic [7:0] RST_LAT_A = pxp_pkg::PXP_RST_LAT_A,
  parameter logic [7:0] RST_LAT_B = pxp_pkg::PXP_RST_LAT_B
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_select_lo_pin_i,
  input  wire logic       addr_select_hi_pin_i,
  input  wire logic [3:0] open_drain_io_ports_i,
  output logic      [3:0] open_drain_io_ports_o,
  output logic      [3:0] open_drain_io_ports_oe_o,
  output logic            group_a_out_0_o,
  output logic            group_a_out_1_o,
  output logic            group_a_out_6_o,
  output logic            group_a_out_7_o,
  input  wire logic [3:0] group_a_out_pins_i,
  output logic      [7:0] group_b_outputs_o,
  input  wire logic [7:0] group_b_outputs_i,
  output logic            change_alert_n_o
);
  import pxp_pkg::*;

  typedef struct packed {
    pxp_st_e    st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic       grp_b;
    logic       rnw;
    logic       nxt_flags;
    logic       rd_a;
    logic [7:0] flag_hold;
    logic [3:0] snap;
    logic [3:0] flags;
    logic       alert_n;
    logic       sda_oe;
    logic       scl_d;
    logic       sda_d;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
  } pxp_main_s;

  localparam pxp_main_s RST_STATE = '{
    st:        PXP_ST_IDLE,
    bitcnt:    4'h0,
    shreg:     8'h00,
    grp_b:     1'b0,
    rnw:       1'b0,
    nxt_flags: 1'b0,
    rd_a:      1'b0,
    flag_hold: 8'h00,
    snap:      RST_LAT_A[PXP_IO_MSB:PXP_IO_LSB],
    flags:     4'h0,
    alert_n:   1'b1,
    sda_oe:    1'b0,
    scl_d:     1'b1,
    sda_d:     1'b1,
    lat_a:     RST_LAT_A,
    lat_b:     RST_LAT_B
  };

  pxp_main_s q;
  pxp_main_s d;

  logic [19:0] raw_in;
  logic [19:0] syn_in;
  logic        scl_s;
  logic        sda_s;
  logic        sel_lo_s;
  logic        sel_hi_s;
  logic [3:0]  io_live;
  logic [3:0]  a_out_live;
  logic [7:0]  b_live;
  pxp_lvl_e    lvl_lo;
  pxp_lvl_e    lvl_hi;

  // Every pad input crosses into the clock domain here
  assign raw_in = {group_b_outputs_i, group_a_out_pins_i,
                   open_drain_io_ports_i, addr_select_hi_pin_i,
                   addr_select_lo_pin_i, sda_i, scl_i};

  pxp_sync #(
    .WIDTH (20)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (raw_in),
    .sync_o  (syn_in)
  );

  assign scl_s      = syn_in[0];
  assign sda_s      = syn_in[1];
  assign sel_lo_s   = syn_in[2];
  assign sel_hi_s   = syn_in[3];
  assign io_live    = syn_in[7:4];
  assign a_out_live = syn_in[11:8];
  assign b_live     = syn_in[19:12];

  pxp_lvl_dec u_dec_lo (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .scl_i   (scl_s),
    .sda_i   (sda_s),
    .pin_i   (sel_lo_s),
    .level_o (lvl_lo)
  );

  pxp_lvl_dec u_dec_hi (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .scl_i   (scl_s),
    .sda_i   (sda_s),
    .pin_i   (sel_hi_s),
    .level_o (lvl_hi)
  );

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       take_snap;
  logic       addr_hit;
  logic [3:0] addr_low;
  logic [1:0] lo_bits;
  logic [1:0] hi_bits;
  logic [3:0] diff;
  logic [7:0] a_byte;

  always_comb begin
    case (lvl_lo)
      PXP_LVL_GND: lo_bits = PXP_LO_GND;
      PXP_LVL_VDD: lo_bits = PXP_LO_VDD;
      PXP_LVL_SCL: lo_bits = PXP_LO_SCL;
      default:     lo_bits = PXP_LO_SDA;
    endcase
    case (lvl_hi)
      PXP_LVL_GND: hi_bits = PXP_HI_GND;
      PXP_LVL_VDD: hi_bits = PXP_HI_VDD;
      PXP_LVL_SCL: hi_bits = PXP_HI_SCL;
      default:     hi_bits = PXP_HI_SDA;
    endcase
  end

  assign addr_low = {hi_bits, lo_bits};

  // group A byte from pins, outputs read back as inputs
  assign a_byte = {a_out_live[3], a_out_live[2], io_live,
                   a_out_live[1], a_out_live[0]};

  // only ports whose latch is high act as inputs
  assign diff = (io_live ^ q.snap) & q.lat_a[PXP_IO_MSB:PXP_IO_LSB];

  always_comb begin
    d = q;
    take_snap = 1'b0;
    addr_hit = 1'b0;
    d.scl_d = scl_s;
    d.sda_d = sda_s;
    scl_rise = scl_s & ~q.scl_d;
    scl_fall = ~scl_s & q.scl_d;
    // data moves only with SCL low, so an edge on SDA
    // while SCL stays high is a bus condition
    start_c = scl_s & q.scl_d & q.sda_d & ~sda_s;
    stop_c  = scl_s & q.scl_d & ~q.sda_d & sda_s;

    if (start_c) begin
      d.st = PXP_ST_ADDR;
      d.bitcnt = 4'h0;
      d.sda_oe = 1'b0;
      d.rd_a = 1'b0;
    end else if (stop_c) begin
      d.st = PXP_ST_IDLE;
      d.sda_oe = 1'b0;
      d.rd_a = 1'b0;
    end else begin
      case (q.st)
        PXP_ST_ADDR: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == PXP_BIT_FULL) begin
            if (q.shreg[7:5] == PXP_PFX_A ||
                q.shreg[7:5] == PXP_PFX_B) begin
              addr_hit = (q.shreg[4:1] == addr_low);
            end
            d.grp_b = (q.shreg[7:5] == PXP_PFX_B);
            d.rnw = q.shreg[0];
            if (addr_hit) begin
              d.sda_oe = 1'b1;
              d.st = PXP_ST_ADDR_ACK;
            end else begin
              d.st = PXP_ST_IGNORE;
            end
          end
        end
        PXP_ST_ADDR_ACK: begin
          if (scl_rise) begin
            take_snap = 1'b1;
            d.nxt_flags = 1'b1;
            // addressed group's data from the pins
            d.shreg = q.grp_b ? b_live : a_byte;
            if (!q.grp_b) begin
              // only group A clears the alert
              d.alert_n = 1'b1;
              // alert held off for the read
              d.rd_a = q.rnw;
            end
          end else if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.rnw) begin
              d.sda_oe = ~q.shreg[7];
              d.st = PXP_ST_RD_DATA;
            end else begin
              d.sda_oe = 1'b0;
              d.st = PXP_ST_WR_DATA;
            end
          end
        end
        PXP_ST_WR_DATA: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda_s};
            d.bitcnt = q.bitcnt + 4'h1;
          end else if (scl_fall && q.bitcnt == PXP_BIT_FULL) begin
            // each byte sets the whole group
            if (q.grp_b) begin
              d.lat_b = q.shreg;
            end else begin
              d.lat_a = q.shreg;
            end
            // ninth bit held low by us
            d.sda_oe = 1'b1;
            d.st = PXP_ST_WR_ACK;
          end
        end
        PXP_ST_WR_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            d.st = PXP_ST_WR_DATA;
          end
        end
        PXP_ST_RD_DATA: begin
          if (scl_fall) begin
            if (q.bitcnt == PXP_BIT_LAST) begin
              d.sda_oe = 1'b0;
              d.st = PXP_ST_RD_ACK;
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        PXP_ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              // no ack: snapshot kept, alert left alone
              d.st = PXP_ST_IGNORE;
            end else if (q.grp_b) begin
              d.shreg = b_live;
            end else if (q.nxt_flags) begin
              // flags captured at the last sample
              d.shreg = q.flag_hold;
              d.nxt_flags = 1'b0;
            end else begin
              // new pair: resample and reset flags
              take_snap = 1'b1;
              d.shreg = a_byte;
              d.nxt_flags = 1'b1;
            end
          end else if (scl_fall) begin
            d.bitcnt = 4'h0;
            d.sda_oe = ~q.shreg[7];
            d.st = PXP_ST_RD_DATA;
          end
        end
        PXP_ST_IGNORE: begin
          d.sda_oe = 1'b0;
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // snapshot is exactly the data being sent; a change
    // in the sampling cycle moves into the held flags, not lost
    if (take_snap) begin
      d.snap = io_live;
      d.flag_hold = 8'h00;
      d.flag_hold[PXP_IO_MSB:PXP_IO_LSB] = q.flags | diff;
      d.flags = 4'h0;
    end else begin
      d.flags = q.flags | diff;
    end

    // alert only outside a group A read, and only for
    // changes not yet resampled into sent data
    if (!d.rd_a && d.flags != 4'h0) begin
      d.alert_n = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // Open-drain pads only ever drive low
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign open_drain_io_ports_o = 4'h0;
  assign open_drain_io_ports_oe_o = ~q.lat_a[PXP_IO_MSB:PXP_IO_LSB];
  assign group_a_out_0_o = q.lat_a[0];
  assign group_a_out_1_o = q.lat_a[1];
  assign group_a_out_6_o = q.lat_a[6];
  assign group_a_out_7_o = q.lat_a[7];
  assign group_b_outputs_o = q.lat_b;
  assign change_alert_n_o = q.alert_n;

endmodule
`default_nettype wire

// ---- verification/pxp_master.sv ----
// Serial bus master model driving the expander's clock and data lines
`timescale 1ns/10ps
`default_nettype none

module pxp_master (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // master owns the clock, idle high
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge clock_i);
  endtask

  // data moves a cycle after the clock falls
  task automatic bit_io(input logic v, output logic r);
    @(posedge clock_i);
    sda_oe_o <= ~v;
    repeat (3) @(posedge clock_i);
    scl_o <= 1'b1;
    half();
    r = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic start();
    sda_oe_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    @(posedge clock_i);
    sda_oe_o <= 1'b1;
    repeat (3) @(posedge clock_i);
    scl_o <= 1'b1;
    half();
    sda_oe_o <= 1'b0;
    half();
  endtask

  task automatic byte_io(input logic [7:0] d, input logic av,
                         output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(av, a);
  endtask
endmodule

`default_nettype wire

// ---- verification/pxp_expander_chk.sv ----
// Pin-level timing checks on the expander front end
`timescale 1ns/10ps
`default_nettype none

module pxp_chk (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_o,
  input  wire logic       sda_oe_o,
  input  wire logic [3:0] open_drain_io_ports_o,
  input  wire logic [3:0] open_drain_io_ports_oe_o,
  input  wire logic       group_a_out_0_o,
  input  wire logic       group_a_out_1_o,
  input  wire logic       group_a_out_6_o,
  input  wire logic       group_a_out_7_o,
  input  wire logic [7:0] group_b_outputs_o,
  input  wire logic       change_alert_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  wire logic [7:0] outs_a = {group_a_out_7_o, group_a_out_6_o,
    open_drain_io_ports_oe_o, group_a_out_1_o, group_a_out_0_o};

  pin_drive_zero_a: assert property (sda_o == 1'b0)
    else $error("open-drain drive value not low");
  io_drive_zero_a: assert property (open_drain_io_ports_o == 4'h0)
    else $error("port pull value not low");
  sda_move_low_a: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
    else $error("data pull-down moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("pull-down dropped within one bit");
  release_hold_a: assert property ($fell(sda_oe_o) |-> !sda_oe_o [*6])
    else $error("released bit shorter than one bit");
  b_latch_low_a: assert property ($changed(group_b_outputs_o) |-> !$past(scl_i, 2))
    else $error("group b outputs moved while clock high");
  a_latch_hold_a: assert property (scl_i && $past(scl_i, 2) |-> $stable(outs_a))
    else $error("group a outputs moved while clock high");
  alert_clear_a: assert property ($rose(change_alert_n_o) |-> $past(scl_i, 2))
    else $error("alert released outside an acknowledge");
  reset_idle_a: assert property ($fell(rst_i) |-> change_alert_n_o && !sda_oe_o)
    else $error("bus or alert busy after reset");

  cover property ($rose(sda_oe_o));
  cover property ($fell(change_alert_n_o));
  cover property ($changed(group_b_outputs_o));
endmodule

bind pxp_expander pxp_chk u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .open_drain_io_ports_o(open_drain_io_ports_o),
  .open_drain_io_ports_oe_o(open_drain_io_ports_oe_o),
  .group_a_out_0_o(group_a_out_0_o), .group_a_out_1_o(group_a_out_1_o),
  .group_a_out_6_o(group_a_out_6_o), .group_a_out_7_o(group_a_out_7_o),
  .group_b_outputs_o(group_b_outputs_o),
  .change_alert_n_o(change_alert_n_o)
);

`default_nettype wire

// ---- verification/test_dual_address_i2c_port_expander.sv ----
// Self-checking bench for the dual-address serial port expander
`timescale 1ns/10ps
`default_nettype none

module test_dual_address_i2c_port_expander;
  import pxp_pkg::*;
  localparam logic [7:0] ADR_A = {PXP_PFX_A, PXP_HI_GND, PXP_LO_GND, 1'b0};
  localparam logic [7:0] ADR_B = {PXP_PFX_B, PXP_HI_GND, PXP_LO_GND, 1'b0};
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic       scl, m_oe, d_oe, a0, a1, a6, a7, alert_n, ak;
  logic [3:0] io_ext  = 4'hf;
  logic [3:0] io_oe;
  logic [7:0] b_o, rd, e;
  logic [7:0] b_frc   = 8'h00;
  logic       sel_mode = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] lat_a   = PXP_RST_LAT_A;
  logic [7:0] lat_b   = PXP_RST_LAT_B;
  int         fails   = 0;
  int         checks  = 0;
  wire logic  sda     = ~(d_oe | m_oe);

  always #12.5 clock_i = ~clock_i;

  pxp_master m (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  pxp_expander uut (
    .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(d_oe),
    .addr_select_lo_pin_i(sel_mode & scl),
    .addr_select_hi_pin_i(sel_mode & sda),
    .open_drain_io_ports_i(io_ext & ~io_oe), .open_drain_io_ports_o(),
    .open_drain_io_ports_oe_o(io_oe),
    .group_a_out_0_o(a0), .group_a_out_1_o(a1),
    .group_a_out_6_o(a6), .group_a_out_7_o(a7),
    .group_a_out_pins_i({a7, a6, a1, a0}),
    .group_b_outputs_o(b_o), .group_b_outputs_i(b_o ^ b_frc),
    .change_alert_n_o(alert_n)
  );

  function automatic logic [7:0] outs_a();
    return {a7, a6, ~io_oe, a1, a0};
  endfunction

  function automatic logic [7:0] pins_a();
    return (lat_a & 8'hc3) | {2'h0, io_ext & lat_a[5:2], 2'h0};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle();
    repeat (10) @(posedge clock_i);
  endtask

  task automatic xb(input logic [7:0] d, input logic av);
    m.byte_io(d, av, rd, ak);
  endtask

  // Byte transfer with a pin change landing in its middle
  task automatic xb_chg(input logic av, input logic grp, input logic [7:0] v);
    fork
      xb(8'hff, av);
      begin
        repeat (20) @(posedge clock_i);
        if (grp)
          b_frc <= v;
        else
          io_ext <= v[3:0];
      end
    join
  endtask

  // Group A writes keep the open-drain ports released as inputs
  task automatic wr(input logic grp);
    logic [7:0] d;
    m.start();
    xb(grp ? ADR_B : ADR_A, 1'b1);
    check(8'(ak), 8'h00);
    repeat (2) begin
      d = 8'($urandom()) | (grp ? 8'h00 : 8'h3c);
      xb(d, 1'b1);
      if (grp)
        lat_b = d;
      else
        lat_a = d;
      check(8'(ak), 8'h00);
      check(grp ? b_o : outs_a(), d);
    end
    m.stop();
  endtask

  initial begin
    e = 8'($urandom(21982));
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    check({alert_n, d_oe, 6'h00}, 8'h80);
    check(outs_a(), lat_a);
    check(b_o, lat_b);
    wr(1'b0);
    wr(1'b1);
    for (int i = 0; i < 2; i++) begin
      m.start();
      xb(i ? 8'hfe : {PXP_PFX_A, PXP_HI_VDD, PXP_LO_GND, 1'b0}, 1'b1);
      check(8'(ak), 8'h01);
      xb(8'h00, 1'b1);
      check(8'(ak), 8'h01);
      m.stop();
    end
    check(outs_a(), lat_a);
    io_ext <= 4'he;
    settle();
    check(8'(alert_n), 8'h00);
    wr(1'b1);
    check(8'(alert_n), 8'h00);
    io_ext <= 4'hc;
    settle();
    m.start();
    xb(ADR_A | 8'h01, 1'b1);
    check(8'(ak), 8'h00);
    exp_q.push_back(pins_a());
    exp_q.push_back(8'h08);
    xb(8'hff, 1'b0);
    check(rd, exp_q.pop_front());
    check(8'(alert_n), 8'h01);
    xb_chg(1'b0, 1'b0, 8'h08);
    check(rd, exp_q.pop_front());
    check(8'(alert_n), 8'h01);
    xb(8'hff, 1'b1);
    check(rd, pins_a());
    m.stop();
    settle();
    check(8'(alert_n), 8'h01);
    m.start();
    xb(ADR_A | 8'h01, 1'b1);
    e = pins_a();
    xb_chg(1'b1, 1'b0, 8'h09);
    check(rd, e);
    check(8'(alert_n), 8'h01);
    m.stop();
    settle();
    check(8'(alert_n), 8'h00);
    b_frc <= 8'($urandom()) | 8'h01;
    m.start();
    xb(ADR_B | 8'h01, 1'b1);
    e = lat_b ^ b_frc;
    xb_chg(1'b0, 1'b1, ~b_frc);
    check(rd, e);
    xb(8'hff, 1'b1);
    check(rd, lat_b ^ b_frc);
    m.stop();
    check(b_o, lat_b);
    // Second reset with the straps moved onto the bus lines
    rst_i <= 1'b1;
    sel_mode <= 1'b1;
    io_ext <= 4'hf;
    b_frc <= 8'h00;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    lat_b = PXP_RST_LAT_B;
    repeat (8) @(posedge clock_i);
    check({alert_n, d_oe, 6'h00}, 8'h80);
    check(b_o, lat_b);
    m.start();
    xb(ADR_B, 1'b1);
    check(8'(ak), 8'h01);
    m.stop();
    m.start();
    xb({PXP_PFX_B, PXP_HI_SDA, PXP_LO_SCL, 1'b0}, 1'b1);
    check(8'(ak), 8'h00);
    e = 8'($urandom());
    xb(e, 1'b1);
    check(b_o, e);
    m.stop();
    tally_and_finish();
  end

  // Whole run is about 53 us; a hang stops well past that
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
